// *** src/charger_setpoint_status_regs.sv ***
// i2c register bank: throttle flags, charge current setpoint, voltage cap
`timescale 1ns/100ps
`include "chg_map.svh"
module charger_setpoint_status_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h09,
	parameter logic [15:0] AUTO_WAKE_AMPS = 16'h0000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// i2c pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// charger state
	input wire logic [6:0] throttle_i,
	input wire chg_pkg::batt_sense_t sense_i,
	output chg_pkg::charge_ctrl_t ctrl_o,
	output logic invalid_write_o
);
	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_q1;
	logic rst_n;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [15:0] vcap_def(input logic [1:0] cells);
		case (cells)
			2'h0: vcap_def = `VCAP_1S; // [RULE15]
			2'h1: vcap_def = `VCAP_2S;
			2'h2: vcap_def = `VCAP_3S;
			default: vcap_def = `VCAP_4S;
		endcase
	endfunction

	function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [15:0] amps,
			input logic [15:0] volts, input logic [7:0] flags);
		case (a)
			`AMPS_LO_ADDR: rd_byte = amps[7:0];
			`AMPS_HI_ADDR: rd_byte = amps[15:8];
			`VCAP_LO_ADDR: rd_byte = volts[7:0];
			`VCAP_HI_ADDR: rd_byte = volts[15:8];
			`FLAGS_LO_ADDR: rd_byte = flags;
			default: rd_byte = 8'h00;
		endcase
	endfunction

	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	chg_pkg::regs_state_t s;
	chg_pkg::regs_state_t n;
	logic start;
	logic stop;
	logic rise;
	logic fall;
	logic wr;
	logic one_cell;
	logic ldo_fast;
	logic [7:0] rb;
	logic [15:0] vw;

	assign start = s.scl_q & scl_i & s.sda_q & ~sda_i;
	assign stop = s.scl_q & scl_i & ~s.sda_q & sda_i;
	assign rise = scl_i & ~s.scl_q;
	assign fall = ~scl_i & s.scl_q;
	assign one_cell = (sense_i.cells == 2'h0);
	assign rb = rd_byte(s.ptr, s.amps, s.volts, s.flags);
	assign vw = {s.sr, s.stage_v};

	always_comb begin
		n = s;
		wr = 1'b0;
		ldo_fast = 1'b0;
		n.invalid = 1'b0;
		n.sda_lvl = 1'b0;
		n.scl_q = scl_i;
		n.sda_q = sda_i;
		n.ig_q = sense_i.input_good;
		n.cs_q = sense_i.cell_count_sense;
		n.flags = {1'b0, throttle_i}; // [RULE1]
		// serial engine: bit count rises 0..9, ack on the ninth clock
		if (start) begin
			n.phase = chg_pkg::PH_ADDR;
			n.cnt = 4'h0;
			n.sda_oe_n = 1'b1;
		end else if (stop) begin
			n.phase = chg_pkg::PH_IDLE;
			n.sda_oe_n = 1'b1;
		end else if (s.phase != chg_pkg::PH_IDLE) begin
			if (rise) begin
				n.sr = {s.sr[6:0], sda_i};
				n.cnt = s.cnt + 4'h1;
				if (s.cnt == 4'h8) begin
					n.rd_nack = sda_i;
				end
			end else if (fall) begin
				n.sda_oe_n = 1'b1;
				if (s.cnt == 4'h8) begin
					case (s.phase)
						chg_pkg::PH_ADDR: begin
							if (s.sr[7:1] == DEV_ADDR) begin
								n.sda_oe_n = 1'b0;
								n.phase = s.sr[0] ? chg_pkg::PH_RD : chg_pkg::PH_PTR;
							end else begin
								n.phase = chg_pkg::PH_IDLE;
							end
						end
						chg_pkg::PH_PTR: begin
							n.ptr = s.sr;
							n.sda_oe_n = 1'b0;
							n.phase = chg_pkg::PH_WR;
						end
						chg_pkg::PH_WR: begin
							n.sda_oe_n = 1'b0;
							n.ptr = s.ptr + 8'h01;
							wr = 1'b1;
						end
						default: ;
					endcase
				end else if (s.cnt == 4'h9) begin
					n.cnt = 4'h0;
					if (s.phase == chg_pkg::PH_RD) begin
						if (s.rd_nack) begin
							n.phase = chg_pkg::PH_IDLE;
						end else begin
							n.tx = rb;
							n.ptr = s.ptr + 8'h01;
							n.sda_oe_n = rb[7];
						end
					end
				end else if (s.phase == chg_pkg::PH_RD) begin
					n.sda_oe_n = s.tx[3'(4'h7 - s.cnt)];
				end
			end
		end
		// register writes; low bytes only stage, high byte commits the word
		if (wr) begin
			case (s.ptr)
				`AMPS_LO_ADDR: n.stage_a = s.sr & `AMPS_LO_KEEP; // [RULE9] [RULE21]
				`AMPS_HI_ADDR: begin
					if ((s.sr & `AMPS_HI_BAD) != 8'h00) begin
						n.invalid = 1'b1; // [RULE8]
					end else begin
						n.amps = {s.sr, s.stage_a} & `AMPS_MASK; // [RULE2] [RULE3] [RULE21]
						n.started = s.started | sense_i.input_good; // [RULE16]
					end
				end
				`VCAP_LO_ADDR: n.stage_v = s.sr & `VCAP_LO_KEEP; // [RULE19]
				`VCAP_HI_ADDR: begin
					if ((s.sr & `VCAP_HI_BAD) != 8'h00) begin
						n.invalid = 1'b1;
					end else if (vw == 16'h0000) begin
						n.volts = vcap_def(sense_i.cells); // [RULE18]
						n.amps = 16'h0000;
					end else if (vw >= `VCAP_MIN && vw <= `VCAP_MAX) begin
						n.volts = vw; // [RULE14]
					end
				end
				default: ;
			endcase
		end
		// of the faults, only source loss without overvoltage and pack removal clear the setpoint; other faults leave it
		if ((s.ig_q & ~sense_i.input_good & ~sense_i.input_overvoltage)
				| (s.cs_q & ~sense_i.cell_count_sense)) begin
			n.amps = 16'h0000; // [RULE5] [RULE6] [RULE7]
		end
		if (!sense_i.input_good) begin
			n.started = 1'b0; // [RULE20]
		end
		// straps are caught on the first edge after release
		if (!s.por_done) begin
			n.por_done = 1'b1;
			n.volts = vcap_def(sense_i.cells); // [RULE15]
			n.amps = sense_i.auto_wake ? AUTO_WAKE_AMPS : 16'h0000; // [RULE4]
		end
		// charge control, one cycle behind the registers
		n.ctrl.amps = s.amps;
		n.ctrl.volts = s.volts;
		n.ctrl.charge_en = s.started & sense_i.input_good & (s.amps != 16'h0000);
		n.ctrl.precharge = n.ctrl.charge_en & sense_i.vbat_pre; // [RULE12]
		ldo_fast = n.ctrl.charge_en & one_cell & ~sense_i.vbat_pre & sense_i.vbat_low_sys;
		n.ctrl.sys_at_min = n.ctrl.precharge & ~one_cell; // [RULE11]
		n.ctrl.switch_ldo = sense_i.ldo_sel & (n.ctrl.precharge | ldo_fast); // [RULE10] [RULE13]
		if (!n.ctrl.charge_en) begin
			n.ctrl.clamp = 16'h0000;
		end else if (n.ctrl.precharge) begin
			n.ctrl.clamp = min16(s.amps, `PRE_CLAMP); // [RULE11] [RULE12]
		end else if (ldo_fast) begin
			n.ctrl.clamp = min16(s.amps, `LDO_CLAMP); // [RULE13]
		end else begin
			n.ctrl.clamp = s.amps;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
			s.sda_oe_n <= 1'b1;
			s.phase <= chg_pkg::PH_IDLE;
		end else begin
			s <= n;
		end
	end

	assign sda_o = s.sda_lvl;
	assign sda_oe_n_o = s.sda_oe_n;
	assign ctrl_o = s.ctrl;
	assign invalid_write_o = s.invalid;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	// gated on por_done so that no attempt straddles the release of reset
	chk_flags_follow: assert property (s.por_done |=> s.flags == {1'b0, $past(throttle_i)}) // [RULE1]
		else $error("throttle flags do not follow inputs");
	chk_flags_high: assert property (s.ptr == `FLAGS_HI_ADDR |-> rb == 8'h00) // [RULE1]
		else $error("upper flag byte not zero");
	chk_ctrl_follow: assert property (s.por_done |=> ctrl_o.amps == $past(s.amps)) // [RULE2]
		else $error("control setpoint does not follow register");
	chk_low_staged: assert property (wr && s.ptr == `AMPS_LO_ADDR
			|=> s.stage_a == ($past(s.sr) & `AMPS_LO_KEEP)) // [RULE9]
		else $error("current low byte not staged with mask");
	chk_vcap_ignore: assert property (wr && s.ptr == `VCAP_HI_ADDR && (s.sr & `VCAP_HI_BAD) == 8'h00
			&& vw != 16'h0000 && (vw < `VCAP_MIN || vw > `VCAP_MAX)
			|=> s.volts == $past(s.volts)) // [RULE14]
		else $error("out of range voltage cap accepted");
	chk_no_source: assert property (!sense_i.input_good |=> !ctrl_o.charge_en) // [RULE20]
		else $error("charging without input source");
	chk_amps_fields: assert property ((s.amps & ~`AMPS_MASK) == 16'h0000 || !s.por_done) // [RULE9]
		else $error("current setpoint reserved bits set");
	chk_vcap_range: assert property (s.por_done |-> s.volts >= `VCAP_MIN && s.volts <= `VCAP_MAX) // [RULE14]
		else $error("voltage cap out of range");
	chk_ig_clear: assert property (s.por_done && $fell(sense_i.input_good)
			&& !sense_i.input_overvoltage |=> s.amps == 16'h0000) // [RULE5]
		else $error("current not cleared on input loss");
	chk_pack_clear: assert property (s.por_done && $fell(sense_i.cell_count_sense)
			|=> s.amps == 16'h0000) // [RULE6]
		else $error("current not cleared on pack removal");
	chk_pre_clamp: assert property (ctrl_o.precharge |-> ctrl_o.clamp <= `PRE_CLAMP) // [RULE11]
		else $error("pre-charge clamp exceeded");
	chk_ldo_clamp: assert property (ctrl_o.charge_en && !ctrl_o.precharge && ctrl_o.switch_ldo
			|-> ctrl_o.clamp <= `LDO_CLAMP) // [RULE13]
		else $error("linear fast-charge clamp exceeded");
	chk_bad_write: assert property (wr && s.ptr == `AMPS_HI_ADDR && (s.sr & `AMPS_HI_BAD) != 8'h00
			|=> invalid_write_o && s.amps == $past(s.amps)) // [RULE8]
		else $error("invalid current write accepted");
	chk_zero_vcap: assert property (wr && s.ptr == `VCAP_HI_ADDR && vw == 16'h0000
			&& !$fell(sense_i.input_good) |=> s.amps == 16'h0000 ##1 !ctrl_o.charge_en) // [RULE18]
		else $error("zero voltage write did not stop charge");

	cov_amps_commit: cover property (wr && s.ptr == `AMPS_HI_ADDR ##2 ctrl_o.charge_en);
	cov_vcap_zero: cover property (wr && s.ptr == `VCAP_HI_ADDR && vw == 16'h0000);
	cov_flag_read: cover property (s.phase == chg_pkg::PH_RD && s.ptr == `FLAGS_HI_ADDR);
	cov_pack_removed: cover property (s.por_done && $fell(sense_i.cell_count_sense));
	cov_precharge: cover property (ctrl_o.precharge && ctrl_o.sys_at_min);
endmodule

// *** src/chg_map.svh ***
// register map, field masks and reset values of the charger setpoint block
// Function
// RULE1: seven throttle flags read triggered state, reset zero
// RULE2: current setpoint written as one 16-bit value
// RULE3: setpoint bits sit at value bits 12 to 6
// RULE4: power-on clears current unless auto wakeup
// RULE5: input-good loss clears current, except overvoltage
// RULE6: cell-sense falling clears current setpoint
// RULE7: other faults leave current setpoint untouched
// RULE8: high reserved current bits set means invalid
// RULE9: low reserved current bits ignored, read zero
// RULE10: switch linear mode in pre-charge when selected
// RULE11: multi-cell pre-charge holds sysmin, clamp 384 mA
// RULE12: single cell pre-charge below 3 V, 384 mA
// RULE13: single cell under sysmin keeps linear, 2 A
// RULE14: voltage cap range 1.024-19.2 V, else ignored
// RULE15: power-on voltage cap follows cell count
// RULE16: current write after input-good starts charging
// RULE17: host writes voltage cap before current
// RULE18: zero voltage write restores default, zeroes current
// RULE19: voltage cap bits 14 to 4 valid
// RULE20: input-good high means source present
// RULE21: two bytes, low first, applied atomically
`ifndef CHG_MAP_SVH
`define CHG_MAP_SVH
`define AMPS_LO_ADDR 8'h02
`define AMPS_HI_ADDR 8'h03
`define VCAP_LO_ADDR 8'h04
`define VCAP_HI_ADDR 8'h05
`define FLAGS_LO_ADDR 8'h22
`define FLAGS_HI_ADDR 8'h23
`define AMPS_MASK 16'h1FC0
`define AMPS_LO_KEEP 8'hC0
`define AMPS_HI_BAD 8'hE0
`define VCAP_LO_KEEP 8'hF0
`define VCAP_HI_BAD 8'h80
`define VCAP_MIN 16'h0400
`define VCAP_MAX 16'h4B00
`define VCAP_1S 16'h1060
`define VCAP_2S 16'h20D0
`define VCAP_3S 16'h3130
`define VCAP_4S 16'h41A0
`define PRE_CLAMP 16'h0180
`define LDO_CLAMP 16'h0800
`endif

// *** src/chg_pkg.sv ***
// types shared by the charger setpoint block
package chg_pkg;
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_ADDR = 3'h1,
		PH_PTR = 3'h3,
		PH_WR = 3'h2,
		PH_RD = 3'h6
	} i2c_phase_t;
	typedef struct packed {
		logic [1:0] cells;
		logic cell_count_sense;
		logic vbat_pre;
		logic vbat_low_sys;
		logic ldo_sel;
		logic input_good;
		logic input_overvoltage;
		logic auto_wake;
	} batt_sense_t;
	typedef struct packed {
		logic [15:0] amps;
		logic [15:0] clamp;
		logic [15:0] volts;
		logic charge_en;
		logic precharge;
		logic sys_at_min;
		logic switch_ldo;
	} charge_ctrl_t;
	typedef struct packed {
		logic scl_q;
		logic sda_q;
		i2c_phase_t phase;
		logic [3:0] cnt;
		logic [7:0] sr;
		logic [7:0] tx;
		logic [7:0] ptr;
		logic rd_nack;
		logic sda_oe_n;
		logic sda_lvl;
		logic [7:0] stage_a;
		logic [7:0] stage_v;
		logic [15:0] amps;
		logic [15:0] volts;
		logic started;
		logic ig_q;
		logic cs_q;
		logic por_done;
		logic [7:0] flags;
		logic invalid;
		charge_ctrl_t ctrl;
	} regs_state_t;
endpackage

// *** verif/i2c_host.sv ***
// partner model: i2c host controller reaching the register bank
`timescale 1ns/100ps
module i2c_host #(
	parameter logic [6:0] ADDR = 7'h09
) (
	// clock and bus
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	logic nak;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		nak = 1'b0;
	end
	// --------
	// bit level
	// --------
	// four clocks a half period keeps scl high and low well past three samples
	task automatic half();
		repeat (4) @(posedge clk_i);
		#2;
	endtask
	task automatic start();
		sda_o = 1'b0;
		half();
		scl_o = 1'b0;
		half();
	endtask
	task automatic stop();
		sda_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		sda_o = 1'b1;
		half();
	endtask
	// sda moves only a half period after scl fell, never near a start or stop
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		half();
		scl_o = 1'b1;
		half();
		r = sda_i;
		scl_o = 1'b0;
		half();
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(last, a);
	endtask
	// --------
	// register transfers, low byte first
	// --------
	task automatic wr(input logic [7:0] p, input logic [15:0] v);
		logic [31:0] b;
		logic [7:0] q;
		logic a;
		b = {ADDR, 1'b0, p, v[7:0], v[15:8]};
		start();
		for (int i = 3; i >= 0; i--) begin
			xfer(b[i*8 +: 8], 1'b1, q, a);
			nak = nak | a;
		end
		stop();
	endtask
	task automatic rd(input logic [7:0] p, output logic [15:0] v);
		logic [7:0] q;
		logic a;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, a);
		xfer(p, 1'b1, q, a);
		stop();
		start();
		xfer({ADDR, 1'b1}, 1'b1, q, a);
		xfer(8'hFF, 1'b0, v[7:0], a);
		xfer(8'hFF, 1'b1, v[15:8], a);
		stop();
	endtask
endmodule

// *** verif/test_charger_setpoint_status_regs.sv ***
// self-checking testbench of the charger setpoint and status registers
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_charger_setpoint_status_regs;
	logic clk, arst_n, scl, sda_h, sda_o, sda_oe_n, invalid, inv_seen;
	logic [6:0] throttle;
	logic [15:0] v;
	chg_pkg::batt_sense_t sn;
	chg_pkg::charge_ctrl_t ctrl;
	int mismatches, compares, cycles;
	// released sda is pulled up
	wire logic sda_bus = sda_h & (sda_oe_n | sda_o);
	charger_setpoint_status_regs dut (.clk_i(clk), .arst_n_i(arst_n), .scl_i(scl),
		.sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .throttle_i(throttle),
		.sense_i(sn), .ctrl_o(ctrl), .invalid_write_o(invalid));
	i2c_host host (.clk_i(clk), .sda_i(sda_bus), .scl_o(scl), .sda_o(sda_h));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (invalid)
			inv_seen <= 1'b1;
		if (cycles == 60000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic complete_run();
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_reset();
		host.rd(8'h04, v);
		`CHK(v, 16'h20D0)
		`CHK(ctrl.amps, 16'h0000)
		host.rd(8'h22, v);
		`CHK(v, 16'h0055)
	endtask
	task automatic t_volts();
		logic [15:0] w [5] = '{16'h03F0, 16'h4B10, 16'h0400, 16'h410F, 16'h4B00};
		logic [15:0] e [5] = '{16'h20D0, 16'h20D0, 16'h0400, 16'h4100, 16'h4B00};
		for (int i = 0; i < 5; i++) begin
			host.wr(8'h04, w[i]);
			host.rd(8'h04, v);
			`CHK(v, e[i])
			`CHK(ctrl.volts, e[i])
		end
	endtask
	task automatic t_amps();
		host.wr(8'h02, 16'h1FFF);
		host.rd(8'h02, v);
		`CHK(v, 16'h1FC0)
		`CHK(ctrl.charge_en, 1'b1)
		inv_seen = 1'b0;
		host.wr(8'h02, 16'h20C0);
		`CHK(inv_seen, 1'b1)
		`CHK(ctrl.amps, 16'h1FC0)
		`CHK(host.nak, 1'b0)
	endtask
	task automatic t_clamp();
		host.wr(8'h02, 16'h1000);
		sn.vbat_pre = 1'b1;
		tick(4);
		`CHK(ctrl.clamp, 16'h0180)
		`CHK(ctrl.precharge, 1'b1)
		`CHK(ctrl.sys_at_min, 1'b1)
		`CHK(ctrl.switch_ldo, 1'b1)
		sn.cells = 2'h0;
		tick(4);
		`CHK(ctrl.clamp, 16'h0180)
		sn.vbat_pre = 1'b0;
		sn.vbat_low_sys = 1'b1;
		tick(4);
		`CHK(ctrl.clamp, 16'h0800)
		sn.vbat_low_sys = 1'b0;
		sn.cells = 2'h1;
		tick(4);
		`CHK(ctrl.clamp, 16'h1000)
	endtask
	task automatic t_faults();
		sn.input_overvoltage = 1'b1;
		sn.input_good = 1'b0;
		tick(4);
		`CHK(ctrl.amps, 16'h1000)
		sn.input_overvoltage = 1'b0;
		sn.input_good = 1'b1;
		tick(4);
		sn.input_good = 1'b0;
		tick(4);
		`CHK(ctrl.amps, 16'h0000)
		`CHK(ctrl.charge_en, 1'b0)
		sn.input_good = 1'b1;
		host.wr(8'h02, 16'h0440);
		sn.cell_count_sense = 1'b0;
		tick(4);
		`CHK(ctrl.amps, 16'h0000)
		sn.cell_count_sense = 1'b1;
	endtask
	task automatic t_zero();
		host.wr(8'h02, 16'h0440);
		host.wr(8'h04, 16'h0000);
		host.rd(8'h04, v);
		`CHK(v, 16'h20D0)
		`CHK(ctrl.amps, 16'h0000)
		sn.cells = 2'h3;
		arst_n = 1'b0;
		tick(3);
		arst_n = 1'b1;
		tick(6);
		`CHK(ctrl.volts, 16'h41A0)
	endtask
	initial begin
		arst_n = 1'b0;
		throttle = 7'h55;
		sn = {2'h1, 7'b1001100};
		inv_seen = 1'b0;
		mismatches = 0;
		compares = 0;
		cycles = 0;
		tick(12);
		arst_n = 1'b1;
		tick(4);
		t_reset();
		// voltage cap goes before the current setpoint
		t_volts();
		t_amps();
		t_clamp();
		t_faults();
		t_zero();
		complete_run();
	end
endmodule
